// *** src/pccs_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the PLL control block.
// Assumes: A 200 MHz register clock.
// Notes:   Register indexes are word indexes; the byte address is four times the index.
`ifndef PCCS_CFG_SVH
`define PCCS_CFG_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define PCCS_IDX_RFLG 6'h03
`define PCCS_IDX_SYNR 6'h04
`define PCCS_IDX_REF_DIVIDER_VALUE 6'h05
`define PCCS_IDX_OUTPUT_DIVIDER_VALUE 6'h06
`define PCCS_IDX_IFLG 6'h07
`define PCCS_IDX_INTEN 6'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCCS_RF_PLL_MON 0
`define PCCS_RF_OSC_MON 1
`define PCCS_IF_OSC_QUAL 0
`define PCCS_IF_OSC_CHG 1
`define PCCS_IF_LOCK 3
`define PCCS_IF_LOCK_CHG 4
`define PCCS_IF_PERIODIC 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCCS_RST_SYNR 8'h00
`define PCCS_RST_REF_DIVIDER_VALUE 8'h00
`define PCCS_RST_OUTPUT_DIVIDER_VALUE 5'h03
`define PCCS_RST_INTEN 8'h00
`define PCCS_UNLOCKED_OUTPUT_DIVIDER_VALUE 5'h03

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCCS_CLK_MHZ 200
`define PCCS_LOCK_QUAL_NS 2000
`define PCCS_OSC_QUAL_NS 4000
`define PCCS_LOCK_QUAL_CYC ((`PCCS_LOCK_QUAL_NS * `PCCS_CLK_MHZ + 999) / 1000)
`define PCCS_OSC_QUAL_CYC ((`PCCS_OSC_QUAL_NS * `PCCS_CLK_MHZ + 999) / 1000)
`define PCCS_RAMP_MAX_CYC 32

`endif

// *** src/pccs_pkg.sv ***
// Purpose: Types shared by the PLL control block.
// Assumes: Constants come from pccs_cfg.svh.
// Notes:   None.
package pccs_pkg;

    typedef enum logic [1:0] {
        PCCS_RAMP_IDLE = 2'b01,
        PCCS_RAMP_STEP = 2'b10
    } pccs_ramp_e;

    typedef struct packed {
        logic sysclk_from_pll;
        logic use_internal_ref;
        logic [4:0] ref_divisor;
        logic [1:0] filter_range;
        logic [7:0] vco_factor;
        logic [1:0] vco_range_sel;
        logic [4:0] output_divider_now;
    } pccs_pll_cfg_s;

endpackage : pccs_pkg

// *** src/pccs_qualifier.sv ***
// Purpose: Qualifies a level that must hold for a number of cycles.
// Assumes: restart and cond are synchronous to clk.
// Notes:   Drops at once when cond falls or restart pulses.
`timescale 1ns/1ps
module pccs_qualifier #(
    parameter int QUAL_CYCLES = 400
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic cond,
    output logic qualified
);
    logic [12:0] cnt;
    logic [12:0] next_cnt;
    logic next_qualified;

    always_comb begin
        next_cnt = cnt;
        next_qualified = qualified;
        if (restart || !cond) begin
            next_cnt = 13'h0000;
            next_qualified = 1'b0;
        end else if (!qualified) begin
            if (cnt == 13'(QUAL_CYCLES - 1)) begin
                next_qualified = 1'b1;
            end else begin
                next_cnt = cnt + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 13'h0000;
            qualified <= 1'b0;
        end else begin
            cnt <= next_cnt;
            qualified <= next_qualified;
        end
    end
endmodule : pccs_qualifier

// *** src/pccs_pll_ctrl.sv ***
// Purpose: Register logic of the PLL section: dividers, lock and oscillator status, flags.
// Assumes: APB slave with zero wait states; protect and PLL-select bits come from outside.
// Notes:   Frequencies are shown as divider and factor values, not as real clocks.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "pccs_cfg.svh"
module pccs_pll_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic register_protect,
    input wire logic sysclk_from_pll,
    input wire logic ext_osc_enable,
    input wire logic osc_running,
    input wire logic vco_in_window,
    input wire logic osc_lost,
    input wire logic pll_lost,
    input wire logic periodic_timeout,
    input wire logic full_stop_entry,
    output pccs_pkg::pccs_pll_cfg_s pll_cfg,
    output logic irq
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction : hit
    logic access;
    logic wr;
    logic mapped;
    logic wr_syn;
    logic wr_ref;
    logic wr_post;
    logic div_gate;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign mapped = hit(paddr, `PCCS_IDX_RFLG) || hit(paddr, `PCCS_IDX_SYNR)
                  || hit(paddr, `PCCS_IDX_REF_DIVIDER_VALUE) || hit(paddr, `PCCS_IDX_OUTPUT_DIVIDER_VALUE)
                  || hit(paddr, `PCCS_IDX_IFLG) || hit(paddr, `PCCS_IDX_INTEN);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign div_gate = !register_protect && sysclk_from_pll;
    assign wr_syn = wr && hit(paddr, `PCCS_IDX_SYNR) && div_gate;
    assign wr_ref = wr && hit(paddr, `PCCS_IDX_REF_DIVIDER_VALUE) && div_gate;
    assign wr_post = wr && hit(paddr, `PCCS_IDX_OUTPUT_DIVIDER_VALUE) && sysclk_from_pll;

    // ------------------------------------------------------------------
    // Lock and oscillator qualification
    // ------------------------------------------------------------------
    logic lock;
    logic osc_qualified;
    logic lock_d;
    logic osc_qualified_d;
    logic cfg_restart;
    // Both detectors start over after any accepted SYNR or reference divider write; an output divider write does not restart them.
    assign cfg_restart = wr_syn || wr_ref;
    pccs_qualifier #(.QUAL_CYCLES(`PCCS_LOCK_QUAL_CYC)) u_lock_qual (
        .clk(clk),
        .rst_n(rst_n),
        .restart(cfg_restart),
        .cond(vco_in_window),
        .qualified(lock)
    );
    pccs_qualifier #(.QUAL_CYCLES(`PCCS_OSC_QUAL_CYC)) u_osc_qual (
        .clk(clk),
        .rst_n(rst_n),
        .restart(cfg_restart || full_stop_entry),
        .cond(osc_running && ext_osc_enable),
        .qualified(osc_qualified)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] syn;
    logic [7:0] ref_divider_value;
    logic [4:0] output_divider_value;
    logic [7:0] inten;
    logic [1:0] rflg;
    logic periodic_timeout_flag;
    logic lock_change_flag;
    logic osc_change_flag;
    logic [7:0] next_syn;
    logic [7:0] next_ref_divider_value;
    logic [4:0] next_output_divider_value;
    logic [7:0] next_inten;
    logic [1:0] next_rflg;
    logic next_periodic_timeout_flag;
    logic next_lock_change_flag;
    logic next_osc_change_flag;
    logic wr_rflg;
    logic wr_iflg;
    assign wr_rflg = wr && hit(paddr, `PCCS_IDX_RFLG);
    assign wr_iflg = wr && hit(paddr, `PCCS_IDX_IFLG);
    always_comb begin
        next_syn = wr_syn ? pwdata[7:0] : syn;
        next_ref_divider_value = wr_ref ? pwdata[7:0] : ref_divider_value;
        next_output_divider_value = wr_post ? pwdata[4:0] : output_divider_value;
        next_inten = (wr && hit(paddr, `PCCS_IDX_INTEN)) ? pwdata[7:0] : inten;
        next_rflg = rflg;
        next_periodic_timeout_flag = periodic_timeout_flag;
        next_lock_change_flag = lock_change_flag;
        next_osc_change_flag = osc_change_flag;
        // Clears come first so that a simultaneous event still sets the flag.
        if (wr_rflg) begin
            next_rflg = rflg & ~pwdata[1:0];
        end
        if (wr_iflg) begin
            next_periodic_timeout_flag = periodic_timeout_flag && !pwdata[`PCCS_IF_PERIODIC];
            next_lock_change_flag = lock_change_flag && !pwdata[`PCCS_IF_LOCK_CHG];
            next_osc_change_flag = osc_change_flag && !pwdata[`PCCS_IF_OSC_CHG];
        end
        if (osc_lost) begin
            next_rflg[`PCCS_RF_OSC_MON] = 1'b1;
        end
        if (pll_lost) begin
            next_rflg[`PCCS_RF_PLL_MON] = 1'b1;
        end
        if (periodic_timeout) begin
            next_periodic_timeout_flag = 1'b1;
        end
        if (lock != lock_d) begin
            next_lock_change_flag = 1'b1;
        end
        if (osc_qualified != osc_qualified_d) begin
            next_osc_change_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syn <= `PCCS_RST_SYNR;
            ref_divider_value <= `PCCS_RST_REF_DIVIDER_VALUE;
            output_divider_value <= `PCCS_RST_OUTPUT_DIVIDER_VALUE;
            inten <= `PCCS_RST_INTEN;
            rflg <= 2'h0;
            periodic_timeout_flag <= 1'b0;
            lock_change_flag <= 1'b0;
            osc_change_flag <= 1'b0;
            lock_d <= 1'b0;
            osc_qualified_d <= 1'b0;
        end else begin
            syn <= next_syn;
            ref_divider_value <= next_ref_divider_value;
            output_divider_value <= next_output_divider_value;
            inten <= next_inten;
            rflg <= next_rflg;
            periodic_timeout_flag <= next_periodic_timeout_flag;
            lock_change_flag <= next_lock_change_flag;
            osc_change_flag <= next_osc_change_flag;
            lock_d <= lock;
            osc_qualified_d <= osc_qualified;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] iflg;
    assign iflg = {periodic_timeout_flag, 2'b00, lock_change_flag, lock,
                   1'b0, osc_change_flag, osc_qualified};

    always_comb begin
        prdata = 32'h00000000;
        if (hit(paddr, `PCCS_IDX_RFLG)) begin
            prdata[1:0] = rflg;
        end else if (hit(paddr, `PCCS_IDX_SYNR)) begin
            prdata[7:0] = syn;
        end else if (hit(paddr, `PCCS_IDX_REF_DIVIDER_VALUE)) begin
            prdata[7:0] = ref_divider_value;
        end else if (hit(paddr, `PCCS_IDX_OUTPUT_DIVIDER_VALUE)) begin
            prdata[4:0] = output_divider_value;
        end else if (hit(paddr, `PCCS_IDX_IFLG)) begin
            prdata[7:0] = iflg;
        end else if (hit(paddr, `PCCS_IDX_INTEN)) begin
            prdata[7:0] = inten;
        end
    end
    assign irq = |(iflg & inten & 8'h92);

    // ------------------------------------------------------------------
    // Output divider ramp
    // ------------------------------------------------------------------
    // Stepping one count per cycle spares the regulator a sudden load step.
    pccs_pkg::pccs_ramp_e ramp_state;
    pccs_pkg::pccs_ramp_e next_ramp_state;
    logic [4:0] div_now;
    logic [4:0] next_div_now;
    logic [4:0] div_target;
    assign div_target = lock ? output_divider_value : `PCCS_UNLOCKED_OUTPUT_DIVIDER_VALUE;
    always_comb begin
        next_div_now = div_now;
        next_ramp_state = ramp_state;
        case (ramp_state)
            pccs_pkg::PCCS_RAMP_IDLE: begin
                if (div_now != div_target) begin
                    next_ramp_state = pccs_pkg::PCCS_RAMP_STEP;
                end
            end
            pccs_pkg::PCCS_RAMP_STEP: begin
                if (div_now < div_target) begin
                    next_div_now = div_now + 5'h01;
                end else if (div_now > div_target) begin
                    next_div_now = div_now - 5'h01;
                end else begin
                    next_ramp_state = pccs_pkg::PCCS_RAMP_IDLE;
                end
            end
            default: begin
                next_ramp_state = pccs_pkg::PCCS_RAMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_state <= pccs_pkg::PCCS_RAMP_IDLE;
            div_now <= `PCCS_UNLOCKED_OUTPUT_DIVIDER_VALUE;
        end else begin
            ramp_state <= next_ramp_state;
            div_now <= next_div_now;
        end
    end

    // ------------------------------------------------------------------
    // Configuration to the analog PLL
    // ------------------------------------------------------------------
    pccs_pkg::pccs_pll_cfg_s next_cfg;
    always_comb begin
        next_cfg.sysclk_from_pll = sysclk_from_pll;
        next_cfg.use_internal_ref = !ext_osc_enable;
        next_cfg.ref_divisor = 5'(ref_divider_value[3:0]) + 5'h01;
        next_cfg.filter_range = ext_osc_enable ? ref_divider_value[7:6] : 2'b00;
        next_cfg.vco_factor = {1'b0, syn[5:0], 1'b0} + 8'h02;
        next_cfg.vco_range_sel = syn[7:6];
        next_cfg.output_divider_now = div_now;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_cfg <= '0;
        end else begin
            pll_cfg <= next_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [5:0] ramp_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cnt <= 6'h00;
        end else if (div_now == div_target) begin
            ramp_cnt <= 6'h00;
        end else if (ramp_cnt != 6'h3f) begin
            ramp_cnt <= ramp_cnt + 6'h01;
        end
    end

    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_osc_mon_set: assert property (osc_lost |=> rflg[1])
        else $error("Oscillator monitor flag not set.");
    chk_pll_mon_set: assert property (pll_lost |=> rflg[0])
        else $error("PLL monitor flag not set.");
    chk_syn_gated: assert property (wr && hit(paddr, `PCCS_IDX_SYNR) && register_protect
        |=> $stable(syn))
        else $error("Protected multiplier write took effect.");
    chk_write_unlocks: assert property ((wr_syn || wr_ref) |=> !lock && !osc_qualified)
        else $error("Divider write left status set.");
    chk_post_gated: assert property (wr && hit(paddr, `PCCS_IDX_OUTPUT_DIVIDER_VALUE) && !sysclk_from_pll
        |=> $stable(output_divider_value))
        else $error("Output divider write taken without PLL select.");
    chk_periodic_set: assert property (periodic_timeout |=> iflg[7])
        else $error("Periodic flag not set.");
    chk_lock_change: assert property ($changed(lock) |=> lock_change_flag)
        else $error("Lock change flag not set.");
    chk_osc_change: assert property ($changed(osc_qualified) |=> osc_change_flag)
        else $error("Oscillator change flag not set.");
    chk_full_stop: assert property (full_stop_entry |=> !osc_qualified)
        else $error("Full stop did not clear oscillator status.");
    chk_ramp_bound: assert property (ramp_cnt <= 6'd32)
        else $error("Output divider ramp too slow.");
    chk_filter_fixed: assert property (!ext_osc_enable |=> pll_cfg.filter_range == 2'b00)
        else $error("Filter range not fixed for internal reference.");
    chk_irq_flag: assert property (irq |-> (lock_change_flag && inten[4])
        || (osc_change_flag && inten[1]) || (periodic_timeout_flag && inten[7]))
        else $error("Interrupt without enabled flag.");

endmodule : pccs_pll_ctrl

// *** testbench/pll_clock_config_status_tb_top.sv ***
// Purpose: Self-checking bench for the PLL register block over APB.
// Assumes: Zero-wait slave; event inputs are one-cycle pulses.
// Notes:   Lock and oscillator waits poll the flag register under a bound.
`timescale 1ns/1ps
module pll_clock_config_status_tb_top;
    typedef struct packed {
        logic [2:0] ctl;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] want;
    } pccs_row_s;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic register_protect = 1'b0;
    logic sysclk_from_pll = 1'b1;
    logic ext_osc_enable = 1'b1;
    logic osc_running = 1'b1;
    logic vco_in_window = 1'b0;
    logic [3:0] ev = 4'h0;
    pccs_pkg::pccs_pll_cfg_s pll_cfg;
    logic irq;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int n_compared = 0;
    // Control column is {protect, pll selected, write}; reads follow every write.
    pccs_row_s rows [21] = '{
        '{3'b010, 8'h0c, 8'h00, 8'h00},
        '{3'b010, 8'h10, 8'h00, 8'h00},
        '{3'b010, 8'h14, 8'h00, 8'h00},
        '{3'b010, 8'h18, 8'h00, 8'h03},
        '{3'b010, 8'h1c, 8'h00, 8'h00},
        '{3'b010, 8'h20, 8'h00, 8'h00},
        '{3'b011, 8'h10, 8'hff, 8'hff},
        '{3'b011, 8'h14, 8'hff, 8'hff},
        '{3'b011, 8'h18, 8'hff, 8'h1f},
        '{3'b011, 8'h20, 8'hff, 8'hff},
        '{3'b011, 8'h1c, 8'hff, 8'h00},
        '{3'b011, 8'h0c, 8'hff, 8'h00},
        '{3'b011, 8'h1c, 8'h00, 8'h00},
        '{3'b111, 8'h10, 8'h05, 8'hff},
        '{3'b111, 8'h14, 8'h00, 8'hff},
        '{3'b111, 8'h18, 8'h02, 8'h02},
        '{3'b001, 8'h10, 8'h05, 8'hff},
        '{3'b001, 8'h14, 8'h00, 8'hff},
        '{3'b001, 8'h18, 8'h04, 8'h02},
        '{3'b011, 8'h10, 8'h05, 8'h05},
        '{3'b011, 8'h18, 8'h1f, 8'h1f}
    };

    pccs_pll_ctrl dut_u (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .register_protect(register_protect),
        .sysclk_from_pll(sysclk_from_pll), .ext_osc_enable(ext_osc_enable),
        .osc_running(osc_running), .vco_in_window(vco_in_window), .osc_lost(ev[0]),
        .pll_lost(ev[1]), .periodic_timeout(ev[2]), .full_stop_entry(ev[3]),
        .pll_cfg(pll_cfg), .irq(irq)
    );

    always #2.5 clk = ~clk;

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    task finish_test;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] w, input logic [31:0] got);
        n_compared++;
        if (got !== w) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, w, got);
        end
    endtask : chk

    // Read data and error are taken at the edge that samples pready high.
    task automatic apb(input logic wnr, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wnr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        if (k >= 20) begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] w);
        apb(1'b0, a, 32'h0);
        chk(nm, w, rd);
        chk("slave error", 32'h0, 32'(er));
    endtask : rdc

    task automatic chk_irq(input logic w);
        @(negedge clk);
        chk("irq", 32'(w), 32'(irq));
    endtask : chk_irq

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask : pulse

    task automatic wait_flags(input logic [31:0] m);
        int k = 0;
        apb(1'b0, 8'h1c, 32'h0);
        while ((rd & m) !== m && k < 500) begin
            k++;
            apb(1'b0, 8'h1c, 32'h0);
        end
        if (k >= 500) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_flags

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    initial begin
        logic [31:0] w;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 21; i++) begin
            @(posedge clk);
            {register_protect, sysclk_from_pll} <= rows[i].ctl[2:1];
            if (rows[i].ctl[0]) wr(rows[i].addr, 32'(rows[i].wd));
            rdc($sformatf("row %0d", i), rows[i].addr, 32'(rows[i].want));
        end
        $display("test register table done");
        repeat (2) @(negedge clk);
        chk("vco factor", 32'h0c, 32'(pll_cfg.vco_factor));
        chk("ref divisor", 32'h10, 32'(pll_cfg.ref_divisor));
        chk("vco range", 32'h0, 32'(pll_cfg.vco_range_sel));
        chk("filter", 32'h3, 32'(pll_cfg.filter_range));
        @(posedge clk);
        ext_osc_enable <= 1'b0;
        sysclk_from_pll <= 1'b0;
        repeat (3) @(negedge clk);
        chk("internal ref", 32'h1, 32'(pll_cfg.use_internal_ref));
        chk("fixed filter", 32'h0, 32'(pll_cfg.filter_range));
        chk("clock select", 32'h0, 32'(pll_cfg.sysclk_from_pll));
        @(posedge clk);
        ext_osc_enable <= 1'b1;
        sysclk_from_pll <= 1'b1;
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped error", 32'h1, 32'(er));
        $display("test config and map done");
        for (int i = 0; i < 2; i++) begin
            w = 32'h2 >> i;
            pulse(i);
            rdc("monitor flag set", 8'h0c, w);
            wr(8'h0c, 32'h0);
            rdc("monitor flag kept", 8'h0c, w);
            wr(8'h0c, w);
            rdc("monitor flag cleared", 8'h0c, 32'h0);
        end
        pulse(2);
        rdc("periodic flag", 8'h1c, 32'h80);
        chk_irq(1'b1);
        wr(8'h20, 32'h0);
        chk_irq(1'b0);
        wr(8'h20, 32'hff);
        wr(8'h1c, 32'h0);
        rdc("periodic kept", 8'h1c, 32'h80);
        wr(8'h1c, 32'h80);
        chk_irq(1'b0);
        rdc("periodic cleared", 8'h1c, 32'h0);
        $display("test event flags done");
        @(negedge clk);
        chk("unlocked divider", 32'h3, 32'(pll_cfg.output_divider_now));
        @(posedge clk);
        vco_in_window <= 1'b1;
        wait_flags(32'h08);
        @(negedge clk);
        chk("ramp gradual", 32'h1, 32'(pll_cfg.output_divider_now < 5'h1f));
        repeat (34) @(negedge clk);
        chk("ramp target", 32'h1f, 32'(pll_cfg.output_divider_now));
        wait_flags(32'h01);
        rdc("locked flags", 8'h1c, 32'h1b);
        chk_irq(1'b1);
        wr(8'h1c, 32'h12);
        rdc("flags cleared", 8'h1c, 32'h09);
        wr(8'h14, 32'h00);
        rdc("status dropped", 8'h1c, 32'h12);
        repeat (34) @(negedge clk);
        chk("unlock divider", 32'h3, 32'(pll_cfg.output_divider_now));
        wait_flags(32'h09);
        wr(8'h1c, 32'h12);
        pulse(3);
        rdc("full stop", 8'h1c, 32'h0a);
        $display("test lock and oscillator done");
        // A second reset in mid-run must bring back the reset values.
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdc("reset divider", 8'h18, 32'h03);
        rdc("reset flags", 8'h1c, 32'h00);
        $display("test reset done");
        finish_test();
    end

    // Handshake and flag waits carry their own bounds; this catches any other hang before the verdict.
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : pll_clock_config_status_tb_top
